// >>> common/sbsp_pkg.sv
package sbsp_pkg;
  // ==========================================
  // Geometry
  localparam int ADDR_W = 10;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int DATA_W = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_LAST = 2'h3;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic STRAP_LINEAR = 1'b0;
  localparam logic STRAP_INTERLEAVED = 1'b1;
  localparam logic [1:0] SYNC_ZERO = 2'h0;
  localparam logic [1:0] SYNC_STRAP_RESET = 2'h3;

  // ==========================================
  // Access state
  typedef enum logic [1:0] {
    SBSP_IDLE = 2'b00,
    SBSP_READ = 2'b01,
    SBSP_WRITE = 2'b10
  } sbsp_state_t;
endpackage

// >>> common/sbsp_wr_if.sv
`timescale 1ns/1ns
// Write path between the port logic and the write buffer
interface sbsp_wr_if;
  import sbsp_pkg::*;
  logic valid;
  logic ready;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic [LANES-1:0] parity;
  logic [LANES-1:0] lane_en;
  modport src (output valid, output addr, output data, output parity, output lane_en, input ready);
  modport dst (input valid, input addr, input data, input parity, input lane_en, output ready);
endinterface

// >>> rtl/sbsp_wbuf.sv
`timescale 1ns/1ns
// Two-entry write buffer; drains at most one word per cycle when drain_ok
module sbsp_wbuf (
  input wire logic clk,
  input wire logic rst,
  input wire logic drain_ok,
  sbsp_wr_if.dst in_port,
  output logic out_valid,
  output logic [sbsp_pkg::ADDR_W-1:0] out_addr,
  output logic [sbsp_pkg::DATA_W+sbsp_pkg::LANES-1:0] out_word,
  output logic [sbsp_pkg::LANES-1:0] out_lane_en
);
  import sbsp_pkg::*;
  localparam int EW = ADDR_W + DATA_W + 2 * LANES;
  logic [EW-1:0] mem [2];
  logic [1:0] count;
  logic wptr;
  logic rptr;
  logic [1:0] next_count;
  logic next_wptr;
  logic next_rptr;
  logic push;
  logic pop;

  assign in_port.ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign {out_addr, out_word, out_lane_en} = mem[rptr];

  always_comb begin
    push = in_port.valid && in_port.ready;
    pop = out_valid && drain_ok;
    next_wptr = push ? ~wptr : wptr;
    next_rptr = pop ? ~rptr : rptr;
    next_count = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 2'h0;
      wptr <= 1'b0;
      rptr <= 1'b0;
    end else begin
      count <= next_count;
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= {in_port.addr, in_port.data, in_port.parity, in_port.lane_en};
    end
  end

  a_buf_bound: assert property (@(posedge clk) disable iff (rst) count <= 2'h2)
    else $error("write buffer count over two");
endmodule

// >>> rtl/sbsp_port.sv
`timescale 1ns/1ns
module sbsp_port #(
  parameter int ADDR_BITS = sbsp_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [sbsp_pkg::ADDR_W-1:0] addr,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_high,
  input wire logic chip_select_third_n,
  input wire logic byte_write_enable_n,
  input wire logic [sbsp_pkg::LANES-1:0] byte_lane_write_select_n,
  input wire logic all_bytes_write_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_strap,
  input wire logic [sbsp_pkg::DATA_W-1:0] data_in,
  output logic [sbsp_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [sbsp_pkg::LANES-1:0] parity_in,
  output logic [sbsp_pkg::LANES-1:0] parity_out,
  output logic [sbsp_pkg::LANES-1:0] parity_oe,
  output logic asleep
);
  import sbsp_pkg::*;

  // ==========================================
  // Pin synchronisers for asynchronous inputs
  logic [1:0] sleep_sync;
  logic [1:0] strap_sync;
  logic [1:0] oe_sync;
  logic sleep_level;
  logic strap_level;
  logic oe_n_level;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_sync <= SYNC_ZERO;
      strap_sync <= SYNC_STRAP_RESET;
      oe_sync <= SYNC_STRAP_RESET;
    end else begin
      sleep_sync <= {sleep_sync[0], sleep_request};
      strap_sync <= {strap_sync[0], burst_order_strap};
      oe_sync <= {oe_sync[0], output_enable_n};
    end
  end

  assign sleep_level = sleep_sync[1];
  assign strap_level = strap_sync[1];
  assign oe_n_level = oe_sync[1];

  // ==========================================
  // Burst address function
  function automatic logic [BURST_W-1:0] burst_addr(input logic [BURST_W-1:0] start,
                                                    input logic [BURST_W-1:0] beat,
                                                    input logic mode);
    if (mode == STRAP_LINEAR) begin
      burst_addr = start + beat;
    end else begin
      burst_addr = start ^ beat;
    end
  endfunction

  // ==========================================
  // Strobe decode
  logic p_take;
  logic c_take;
  logic strobe;
  logic selected_now;
  logic wr_req;
  logic [LANES-1:0] lanes_now;

  always_comb begin
    p_take = !processor_addr_strobe_n && !chip_select_primary_n;
    c_take = !controller_addr_strobe_n && !p_take && processor_addr_strobe_n;
    strobe = (p_take || c_take) && !sleep_level;
    selected_now = !chip_select_primary_n && chip_select_high && !chip_select_third_n;
    if (!all_bytes_write_n) begin
      lanes_now = {LANES{1'b1}};
    end else if (!byte_write_enable_n) begin
      lanes_now = ~byte_lane_write_select_n;
    end else begin
      lanes_now = {LANES{1'b0}};
    end
    wr_req = |lanes_now;
  end

  // ==========================================
  // Access state
  sbsp_state_t state;
  sbsp_state_t next_state;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic [BURST_W-1:0] beat;
  logic [BURST_W-1:0] next_beat;
  logic first_after_desel;
  logic next_first_after_desel;
  logic [ADDR_W-1:0] cur_addr;

  assign cur_addr = {base[ADDR_W-1:BURST_W], burst_addr(base[BURST_W-1:0], beat, strap_level)};

  always_comb begin
    next_state = state;
    next_base = base;
    next_beat = beat;
    next_first_after_desel = 1'b0;
    if (strobe) begin
      next_base = addr;
      next_beat = BURST_ZERO;
      if (!selected_now) begin
        next_state = SBSP_IDLE;
      end else begin
        next_first_after_desel = (state == SBSP_IDLE);
        // Processor strobe ignores write inputs in its first cycle
        next_state = (c_take && wr_req) ? SBSP_WRITE : SBSP_READ;
      end
    end else if (state != SBSP_IDLE && !sleep_level) begin
      if (!burst_step_n) begin
        next_beat = beat + BURST_ONE;
      end
      next_state = wr_req ? SBSP_WRITE : SBSP_READ;
    end else if (sleep_level) begin
      next_state = SBSP_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= SBSP_IDLE;
      base <= '0;
      beat <= BURST_ZERO;
      first_after_desel <= 1'b0;
    end else begin
      state <= next_state;
      base <= next_base;
      beat <= next_beat;
      first_after_desel <= next_first_after_desel;
    end
  end

  // ==========================================
  // Write path through the two-entry buffer
  sbsp_wr_if wr ();
  logic buf_valid;
  logic [ADDR_W-1:0] buf_addr;
  logic [DATA_W+LANES-1:0] buf_word;
  logic [LANES-1:0] buf_lane_en;
  logic write_phase;
  logic drain_ok;

  logic [DATA_W-1:0] data_reg;
  logic [LANES-1:0] parity_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_reg <= '0;
      parity_reg <= '0;
    end else begin
      data_reg <= data_in;
      parity_reg <= parity_in;
    end
  end

  // Write data and lanes are taken at the edge where the write inputs are seen; the array write lands two edges later
  logic [LANES-1:0] lanes_q;
  assign write_phase = (state == SBSP_WRITE);
  assign wr.valid = write_phase;
  assign wr.addr = cur_addr;
  assign wr.data = data_reg;
  assign wr.parity = parity_reg;
  assign wr.lane_en = lanes_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lanes_q <= '0;
    end else begin
      lanes_q <= lanes_now;
    end
  end
  // Array rests while asleep and idle; a pending word commits on wake
  assign drain_ok = !(sleep_level && state == SBSP_IDLE);

  sbsp_wbuf u_wbuf (
    .clk(clk),
    .rst(rst),
    .drain_ok(drain_ok),
    .in_port(wr),
    .out_valid(buf_valid),
    .out_addr(buf_addr),
    .out_word(buf_word),
    .out_lane_en(buf_lane_en)
  );

  // ==========================================
  // Storage; retained through sleep
  logic [ADDR_W-1:0] next_read_addr;
  assign next_read_addr = {next_base[ADDR_W-1:BURST_W],
                           burst_addr(next_base[BURST_W-1:0], next_beat, strap_level)};

  logic [LANE_W:0] mem [LANES][2**ADDR_W];
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W:0] rd_lane;
      always_ff @(posedge clk) begin
        if (buf_valid && drain_ok && buf_lane_en[g]) begin
          mem[g][buf_addr] <= {buf_word[LANES + g*LANE_W +: LANE_W], buf_word[g]};
        end
      end
      // Words still in flight are forwarded, newest first, so a read never sees stale data
      always_comb begin
        if (wr.valid && wr.lane_en[g] && wr.addr == next_read_addr) begin
          rd_lane = {wr.data[g*LANE_W +: LANE_W], wr.parity[g]};
        end else if (buf_valid && buf_lane_en[g] && buf_addr == next_read_addr) begin
          rd_lane = {buf_word[LANES + g*LANE_W +: LANE_W], buf_word[g]};
        end else begin
          rd_lane = mem[g][next_read_addr];
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          data_out[g*LANE_W +: LANE_W] <= '0;
          parity_out[g] <= 1'b0;
        end else if (next_state == SBSP_READ) begin
          {data_out[g*LANE_W +: LANE_W], parity_out[g]} <= rd_lane;
        end
      end
    end
  endgenerate

  // ==========================================
  // Output drive
  always_comb begin
    data_oe = !oe_n_level
              && (state == SBSP_READ)
              && !first_after_desel
              && !sleep_level;
    parity_oe = {LANES{data_oe}};
  end
  assign asleep = sleep_level;

  // ==========================================
  // Checks
  sequence s_proc_load;
    !processor_addr_strobe_n && !chip_select_primary_n && !sleep_level;
  endsequence
  a_strobe_load: assert property (@(posedge clk) disable iff (rst)
    s_proc_load |=> base == $past(addr)) else $error("address not captured");
  a_proc_prio: assert property (@(posedge clk) disable iff (rst)
    (s_proc_load and !controller_addr_strobe_n) |=> state != SBSP_WRITE)
    else $error("controller strobe acted");
  a_cs_gate: assert property (@(posedge clk) disable iff (rst)
    chip_select_primary_n && controller_addr_strobe_n |=> base == $past(base)) else $error("strobe not gated");
  a_beat_zero: assert property (@(posedge clk) disable iff (rst)
    strobe |=> beat == BURST_ZERO) else $error("beat not restarted");
  a_beat_step: assert property (@(posedge clk) disable iff (rst)
    !strobe && state != SBSP_IDLE && !sleep_level && !burst_step_n |=> beat == $past(beat) + BURST_ONE)
    else $error("burst did not step");
  a_beat_hold: assert property (@(posedge clk) disable iff (rst)
    !strobe && burst_step_n |=> beat == $past(beat))
    else $error("burst stepped without request");
  a_float_write: assert property (@(posedge clk) disable iff (rst)
    state == SBSP_WRITE |-> !data_oe) else $error("driven during write");
  a_float_first: assert property (@(posedge clk) disable iff (rst)
    state == SBSP_IDLE && strobe && selected_now |=> !data_oe) else $error("driven after deselect");
  a_float_desel: assert property (@(posedge clk) disable iff (rst)
    state == SBSP_IDLE |-> !data_oe && parity_oe == '0) else $error("driven while deselected");
  a_float_oe: assert property (@(posedge clk) disable iff (rst)
    oe_n_level |-> !data_oe && parity_oe == '0) else $error("driven with oe high");
  a_all_lanes: assert property (@(posedge clk) disable iff (rst)
    !all_bytes_write_n |-> lanes_now == {LANES{1'b1}}) else $error("global write lanes");
  a_byte_gate: assert property (@(posedge clk) disable iff (rst)
    all_bytes_write_n && byte_write_enable_n |-> lanes_now == '0) else $error("write without byte enable");
  a_sleep_idle: assert property (@(posedge clk) disable iff (rst)
    sleep_level |=> state == SBSP_IDLE) else $error("active while asleep");
  a_no_drop: assert property (@(posedge clk) disable iff (rst)
    wr.valid |-> wr.ready) else $error("write word dropped");
endmodule

// >>> dv/sbsp_host_model.sv
`timescale 1ns/1ns
// ==========================================
// Bus master model: one strobe cycle per call on either or both strobes, released just after the sampling edge
module sbsp_host_model (
  input wire logic clk,
  output logic [sbsp_pkg::ADDR_W-1:0] addr,
  output logic processor_addr_strobe_n,
  output logic controller_addr_strobe_n,
  output logic burst_step_n,
  output logic chip_select_primary_n,
  output logic chip_select_high,
  output logic chip_select_third_n,
  output logic byte_write_enable_n,
  output logic [sbsp_pkg::LANES-1:0] byte_lane_write_select_n,
  output logic all_bytes_write_n,
  output logic output_enable_n,
  output logic sleep_request,
  output logic burst_order_strap,
  output logic [sbsp_pkg::DATA_W-1:0] data_in,
  output logic [sbsp_pkg::LANES-1:0] parity_in
);
  import sbsp_pkg::*;
  initial begin
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n} = 3'h7;
    {chip_select_primary_n, chip_select_high, chip_select_third_n} = 3'h2;
    {byte_write_enable_n, byte_lane_write_select_n, all_bytes_write_n} = 6'h3f;
    output_enable_n = 1'b0;
    sleep_request = 1'b0;
    burst_order_strap = STRAP_INTERLEAVED;
    addr = '0;
    {parity_in, data_in} = '0;
  end
  task automatic cycle(input logic p_n, c_n, cs1_n, cs2, input logic [ADDR_W-1:0] a,
                       input logic gw_n, bwe_n, input logic [LANES-1:0] sel_n,
                       input logic [DATA_W+LANES-1:0] wd);
    @(posedge clk);
    #1;
    {processor_addr_strobe_n, controller_addr_strobe_n} = {p_n, c_n};
    {chip_select_primary_n, chip_select_high} = {cs1_n, cs2};
    addr = a;
    all_bytes_write_n = gw_n;
    byte_write_enable_n = bwe_n;
    byte_lane_write_select_n = sel_n;
    {parity_in, data_in} = wd;
    @(posedge clk);
    #1;
    {processor_addr_strobe_n, controller_addr_strobe_n} = 2'h3;
    {byte_write_enable_n, byte_lane_write_select_n, all_bytes_write_n} = 6'h3f;
    // Released lines toggle so stale values cannot pass
    addr = ~addr;
    {parity_in, data_in} = ~{parity_in, data_in};
  endtask
  // Only called between accesses, so the strap never moves mid-burst
  task automatic pins(input logic oe_n, zz, strap);
    output_enable_n = oe_n;
    sleep_request = zz;
    burst_order_strap = strap;
  endtask
  task automatic step(input logic s);
    burst_step_n = s;
  endtask
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  import sbsp_pkg::*;
  localparam int WW = DATA_W + LANES;
  localparam logic L = 1'b0;
  localparam logic H = 1'b1;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n;
  logic chip_select_primary_n, chip_select_high, chip_select_third_n;
  logic byte_write_enable_n, all_bytes_write_n, output_enable_n, sleep_request, burst_order_strap;
  logic [LANES-1:0] byte_lane_write_select_n, parity_in, parity_out, parity_oe;
  logic [DATA_W-1:0] data_in, data_out;
  logic data_oe, asleep;
  int n_fail = 0;
  int checks = 0;
  wire logic [WW-1:0] seen = {parity_out, data_out};
  wire logic [LANES:0] oes = {data_oe, parity_oe};
  always #5 clk = ~clk;
  sbsp_host_model master (.*);
  sbsp_port dut (.*);
  // ==========================================
  // Compare helpers
  function automatic logic [WW-1:0] pat(input logic [ADDR_W-1:0] a);
    return {a[3:0], 12'hc3c, a, a};
  endfunction
  function automatic logic [WW-1:0] merge(input logic [WW-1:0] o, n, input logic [LANES-1:0] sel_n);
    logic [WW-1:0] r;
    r = o;
    for (int g = 0; g < LANES; g++) begin
      if (!sel_n[g]) begin
        r[g*LANE_W +: LANE_W] = n[g*LANE_W +: LANE_W];
        r[DATA_W+g] = n[DATA_W+g];
      end
    end
    return r;
  endfunction
  task automatic chk_word(input string nm, input logic [WW-1:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_flag(input string nm, input logic [LANES:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================
  // Access tasks
  task automatic wait_oe;
    for (int i = 0; i < 3 && data_oe !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (data_oe !== 1'b1) begin
      n_fail++;
      $display("mismatch read_wait expected 1 seen %b", data_oe);
      conclude();
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [WW-1:0] exp);
    master.cycle(L, H, L, H, a, H, H, 4'hf, '0);
    wait_oe();
    chk_word("read", exp, seen);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic gw_n, bwe_n,
                    input logic [LANES-1:0] sel_n, input logic [WW-1:0] wd);
    master.cycle(H, L, L, H, a, gw_n, bwe_n, sel_n, wd);
    chk_flag("write_float", 5'h00, oes);
  endtask
  task automatic burst(input logic [ADDR_W-1:0] a, input logic strap);
    logic [1:0] b;
    master.pins(L, L, strap);
    rd(a, pat(a));
    master.cycle(L, H, L, H, a, H, H, 4'hf, '0);
    master.step(L);
    for (int k = 0; k < 4; k++) begin
      b = (strap == STRAP_INTERLEAVED) ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
      if (k > 0) begin
        @(posedge clk);
        #1;
      end
      chk_word("burst", pat({a[ADDR_W-1:2], b}), seen);
    end
    master.step(H);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) wr(i[ADDR_W-1:0], L, H, 4'hf, pat(i[ADDR_W-1:0]));
    for (int i = 0; i < 8; i++) rd(i[ADDR_W-1:0], pat(i[ADDR_W-1:0]));
    wr(10'h002, H, L, 4'ha, 36'hf_1122_3344);
    rd(10'h002, merge(pat(10'h002), 36'hf_1122_3344, 4'ha));
    master.cycle(H, L, L, H, 10'h003, H, H, 4'h0, 36'h0_dead_beef);
    rd(10'h003, pat(10'h003));
    master.cycle(L, L, L, H, 10'h001, L, L, 4'h0, 36'h0_0bad_0bad);
    wait_oe();
    chk_word("both_strobes", pat(10'h001), seen);
    rd(10'h001, pat(10'h001));
    burst(10'h005, STRAP_INTERLEAVED);
    burst(10'h006, STRAP_LINEAR);
    master.pins(H, L, STRAP_LINEAR);
    repeat (3) @(posedge clk);
    master.cycle(L, H, L, H, 10'h004, H, H, 4'hf, '0);
    chk_flag("oe_high", 5'h00, oes);
    master.pins(L, L, STRAP_LINEAR);
    rd(10'h004, pat(10'h004));
    chk_flag("oe_low", 5'h1f, oes);
    master.cycle(H, L, L, L, 10'h004, H, H, 4'hf, '0);
    chk_flag("deselected", 5'h00, oes);
    master.cycle(L, H, H, H, 10'h005, H, H, 4'hf, '0);
    chk_flag("proc_cs_high", 5'h00, oes);
    master.cycle(L, H, L, H, 10'h006, H, H, 4'hf, '0);
    chk_flag("first_after_deselect", 5'h00, oes);
    wait_oe();
    chk_word("after_deselect", pat(10'h006), seen);
    master.cycle(H, L, L, L, 10'h006, H, H, 4'hf, '0);
    master.pins(L, H, STRAP_LINEAR);
    repeat (3) @(posedge clk);
    #1;
    chk_flag("asleep", 5'h01, {4'h0, asleep});
    wr(10'h007, L, H, 4'hf, 36'h0_5555_aaaa);
    master.pins(L, L, STRAP_LINEAR);
    repeat (3) @(posedge clk);
    rd(10'h007, pat(10'h007));
    conclude();
  end
endmodule
